/* core/tuner_ctrl.sv */
// antenna tuner status and control core with APB register access
`timescale 1ns/1ps
`include "tuner_ctrl_defs.svh"
module tuner_ctrl
   import tuner_ctrl_pkg::*;
#(
   parameter int unsigned RETUNE_CYCLES = `RETUNE_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // detector and transceiver pins
   input  wire detect_t     det_pins,
   input  wire logic [4:0]  chan_n,
   // program memory fetch
   output      logic [11:0] prog_addr,
   output      logic        prog_rd_n,
   input  wire logic [7:0]  prog_data,
   // output port write bus
   output      port_wr_t    port_bus,
   output      logic        port_wr_n,
   // latched element driver outputs
   output      logic [7:0]  cap_relays,
   output      logic [7:0]  ind_relays,
   output      logic [7:0]  lamps,
   // interrupt
   output      logic        irq
);
   // three-stage synchronisers; second and third must agree
   logic [6:0]  det_s1, det_s2, det_s3, det;
   logic [4:0]  ch_s1, ch_s2, ch_s3, ch;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // idle levels: no carrier, vswr fine, no tune command
         det_s1 <= 7'h7E;
         det_s2 <= 7'h7E;
         det_s3 <= 7'h7E;
         det    <= 7'h7E;
         ch_s1  <= 5'h1F;
         ch_s2  <= 5'h1F;
         ch_s3  <= 5'h1F;
         ch     <= 5'h1F;
      end else begin
         det_s1 <= det_pins;
         det_s2 <= det_s1;
         det_s3 <= det_s2;
         for (int i = 0; i < 7; i++) begin
            if (det_s2[i] == det_s3[i]) det[i] <= det_s3[i];
         end
         ch_s1 <= chan_n;
         ch_s2 <= ch_s1;
         ch_s3 <= ch_s2;
         if (ch_s2 == ch_s3) ch <= ch_s3;
      end
   end

   detect_t d;
   assign d = det;
   logic phase_ok, mag_ok, mag_conflict, carrier, in_window;
   assign phase_ok     = d.phase_pos_n & d.phase_neg_n;
   assign mag_ok       = d.impedance_high_n & d.impedance_low_n;
   assign mag_conflict = ~d.impedance_high_n & ~d.impedance_low_n;
   assign carrier      = ~d.carrier_present_n;
   assign in_window    = phase_ok & mag_ok;

   // inverted bcd channel code, decoded to an index
   logic [4:0] ch_code, ch_prev;
   logic [4:0] ch_idx;
   assign ch_code = ~ch;
   assign ch_idx  = (ch_code[4] ? 5'd10 : 5'd0) + ch_code[3:0];

   logic vswr_prev;
   logic vswr_rise, ch_change;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // matches the synchroniser reset so no false wake follows reset
         vswr_prev <= 1'b1;
         ch_prev   <= 5'h00;
      end else begin
         vswr_prev <= d.vswr_ok;
         ch_prev   <= ch_code;
      end
   end
   // a vswr transition marks the start of a transmission
   assign vswr_rise = d.vswr_ok ^ vswr_prev;
   assign ch_change = ch_code != ch_prev;

   // registers
   logic [2:0]          ctrl;
   logic [5:0]          int_stat, int_mask;
   logic [`RELAY_W-1:0] relay_sw;
   logic [7:0]          port_sel, port_data;
   logic                port_go;
   logic [11:0]         prog_req;
   logic                prog_go;
   logic [7:0]          prog_word;

   // channel memory: valid code in the top nibble
   logic [`RELAY_W+3:0] chan_mem [`NUM_CH];
   logic [`RELAY_W-1:0] relay_net;

   ctrl_state_t state;
   logic [31:0] timer;
   logic        tune_ready, retune_ev, tune_start;
   logic [15:0] step_cnt;

   logic wr_en, rd_en;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign pready = 1'b1;

   logic hit;
   always_comb begin
      hit = 1'b1;
      case (paddr)
         `REG_CTRL, `REG_STATUS, `REG_INT_STAT, `REG_INT_MASK,
         `REG_RELAY, `REG_CHAN, `REG_PORT, `REG_PROG_ADDR,
         `REG_PROG_DATA: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= 3'h0;
         int_mask <= 6'h00;
         relay_sw <= '0;
      end else if (wr_en) begin
         case (paddr)
            `REG_CTRL:     ctrl     <= pwdata[2:0];
            `REG_INT_MASK: int_mask <= pwdata[5:0];
            `REG_RELAY:    relay_sw <= pwdata[`RELAY_W-1:0];
            default: ;
         endcase
      end
   end

   // store current relay setting for the current channel with valid code
   always_ff @(posedge mclk) begin
      if (wr_en && paddr == `REG_CTRL && pwdata[`CTRL_STORE]
          && ch_idx < `NUM_CH) begin
         chan_mem[ch_idx] <= {`VALID_CODE, relay_sw};
      end
   end

   // state machine: sleep, wake, load, tune, ready, watch
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= ST_SLEEP;
         timer      <= 32'h0;
         relay_net  <= '0;
         tune_ready <= 1'b0;
         retune_ev  <= 1'b0;
         tune_start <= 1'b0;
         step_cnt   <= 16'h0;
      end else begin
         retune_ev  <= 1'b0;
         tune_start <= 1'b0;
         case (state)
            ST_SLEEP: begin
               timer <= 32'h0;
               if (ch_change) state <= ST_LOAD;
               else if (vswr_rise) state <= ST_WAKE;
            end
            ST_LOAD: begin
               if (ch_idx < `NUM_CH &&
                   chan_mem[ch_idx][`RELAY_W+3:`RELAY_W] == `VALID_CODE)
                  relay_net <= chan_mem[ch_idx][`RELAY_W-1:0];
               state <= ST_SLEEP;
            end
            ST_WAKE: begin
               timer <= 32'h0;
               if (d.tune_cmd) begin
                  tune_start <= 1'b1;
                  tune_ready <= 1'b0;
                  step_cnt   <= 16'h0;
                  state      <= ST_TUNE;
               end else state <= ST_WATCH;
            end
            ST_TUNE: begin
               relay_net <= relay_sw;
               // abandon tuning once the carrier is gone
               if (!carrier) state <= ST_SLEEP;
               else if (in_window && d.vswr_ok) begin
                  tune_ready <= 1'b1;
                  state      <= ST_READY;
               end else step_cnt <= step_cnt + 16'd1;
            end
            ST_READY: begin
               if (ctrl[`CTRL_SLEEP] || !carrier) state <= ST_SLEEP;
            end
            ST_WATCH: begin
               if (d.vswr_ok || !carrier) state <= ST_SLEEP;
               else if (timer >= RETUNE_CYCLES) begin
                  if (ctrl[`CTRL_AUTO]) begin
                     retune_ev  <= 1'b1;
                     tune_start <= 1'b1;
                     tune_ready <= 1'b0;
                     state      <= ST_TUNE;
                  end else state <= ST_SLEEP;
               end else timer <= timer + 32'h1;
            end
            default: state <= ST_SLEEP;
         endcase
      end
   end

   // interrupt status: set wins over write-one clear
   logic [5:0] ev;
   assign ev = {mag_conflict, ch_change, retune_ev,
                tune_start,
                (state == ST_TUNE) & carrier & in_window & d.vswr_ok,
                vswr_rise};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) int_stat <= 6'h00;
      else begin
         for (int i = 0; i < 6; i++) begin
            if (ev[i]) int_stat[i] <= 1'b1;
            else if (wr_en && paddr == `REG_INT_STAT && pwdata[i])
               int_stat[i] <= 1'b0;
         end
      end
   end
   assign irq = |(int_stat & int_mask);

   // output port writes: select and write strobe latch the data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port_sel  <= 8'h00;
         port_data <= 8'h00;
         port_go   <= 1'b0;
      end else begin
         port_go <= wr_en && paddr == `REG_PORT;
         if (wr_en && paddr == `REG_PORT) begin
            port_sel  <= pwdata[15:8];
            port_data <= pwdata[7:0];
         end
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port_bus.sel  <= 8'h00;
         port_bus.data <= 8'h00;
         port_wr_n     <= 1'b1;
      end else begin
         port_bus.sel  <= port_sel;
         port_bus.data <= port_data;
         port_wr_n     <= ~port_go;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cap_relays <= 8'h00;
         ind_relays <= 8'h00;
         lamps      <= 8'h00;
      end else if (!port_wr_n) begin
         if (port_bus.sel == `PORT_CAP) cap_relays <= port_bus.data;
         if (port_bus.sel == `PORT_IND) ind_relays <= port_bus.data;
         if (port_bus.sel == `PORT_LAMP) lamps <= port_bus.data;
      end
   end

   // program fetch: address then a one-cycle low read strobe
   logic [1:0] fetch_ph;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prog_req  <= 12'h000;
         prog_go   <= 1'b0;
         prog_addr <= 12'h000;
         prog_rd_n <= 1'b1;
         prog_word <= 8'h00;
         fetch_ph  <= 2'd0;
      end else begin
         prog_go <= wr_en && paddr == `REG_PROG_ADDR;
         if (wr_en && paddr == `REG_PROG_ADDR) prog_req <= pwdata[11:0];
         case (fetch_ph)
            2'd0: if (prog_go) begin
               prog_addr <= prog_req;
               fetch_ph  <= 2'd1;
            end
            2'd1: begin
               prog_rd_n <= 1'b0;
               fetch_ph  <= 2'd2;
            end
            2'd2: begin
               prog_word <= prog_data;
               prog_rd_n <= 1'b1;
               fetch_ph  <= 2'd0;
            end
            default: fetch_ph <= 2'd0;
         endcase
      end
   end

   always_comb begin
      prdata = 32'h0;
      if (rd_en) begin
         case (paddr)
            `REG_CTRL:      prdata = {29'h0, ctrl};
            `REG_STATUS:    prdata = {16'h0, step_cnt[7:0], tune_ready,
                                      mag_conflict, carrier, d.vswr_ok,
                                      mag_ok, phase_ok, state == ST_SLEEP,
                                      d.tune_cmd};
            `REG_INT_STAT:  prdata = {26'h0, int_stat};
            `REG_INT_MASK:  prdata = {26'h0, int_mask};
            `REG_RELAY:     prdata = {11'h0, relay_net};
            `REG_CHAN:      prdata = {27'h0, ch_idx};
            `REG_PROG_DATA: prdata = {23'h0, ~prog_rd_n | (fetch_ph != 2'd0),
                                      prog_word};
            default:        prdata = 32'h0;
         endcase
      end
   end
endmodule // tuner_ctrl

/* core/tuner_ctrl_defs.svh */
// constants for the antenna tuner controller
`ifndef TUNER_CTRL_DEFS_SVH
`define TUNER_CTRL_DEFS_SVH
`define CLK_NS           25
`define RETUNE_MS        100
`define RETUNE_CYC       ((`RETUNE_MS * 1000000) / `CLK_NS)
`define STEP_CYC         16'd8
`define NUM_CH           21
`define VALID_CODE       4'hA
`define RELAY_W          21
`define LAMP_READY_BIT   5
`define PORT_CAP         8'h01
`define PORT_IND         8'h02
`define PORT_LAMP        8'h04
`define REG_CTRL         12'h000
`define REG_STATUS       12'h004
`define REG_INT_STAT     12'h008
`define REG_INT_MASK     12'h00C
`define REG_RELAY        12'h010
`define REG_CHAN         12'h014
`define REG_PORT         12'h018
`define REG_PROG_ADDR    12'h01C
`define REG_PROG_DATA    12'h020
`define CTRL_AUTO        0
`define CTRL_STORE       1
`define CTRL_SLEEP       2
`endif

/* core/tuner_ctrl_pkg.sv */
// types for the antenna tuner controller
package tuner_ctrl_pkg;
   typedef struct packed {
      logic phase_pos_n;
      logic phase_neg_n;
      logic impedance_high_n;
      logic impedance_low_n;
      logic carrier_present_n;
      logic vswr_ok;
      logic tune_cmd;
   } detect_t;
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] data;
   } port_wr_t;
   typedef enum logic [2:0] {
      ST_SLEEP, ST_WAKE, ST_LOAD, ST_TUNE, ST_READY, ST_WATCH
   } ctrl_state_t;
endpackage

/* testbench/antenna_tuner_status_control_bench.sv */
// self-checking bench for the tuner controller
`timescale 1ns/1ps
`include "tuner_ctrl_defs.svh"
module antenna_tuner_status_control_bench;
   import tuner_ctrl_pkg::*;
   logic        mclk = 0;
   logic        rst_n = 0;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic        pready, pslverr, err, prog_rd_n, port_wr_n, irq;
   logic [11:0] prog_addr;
   logic [7:0]  prog_data, cap_relays, ind_relays, lamps;
   port_wr_t    port_bus;
   detect_t     det_pins;
   logic [4:0]  chan_n, chan = 5'h01;
   logic [1:0]  phase = 0, mag = 0;
   logic        rf_on = 0, swr_high = 0, tune_req = 0;
   int          n_errors = 0, num_checks = 0, i;
   initial forever #12.5 mclk = !mclk;
   // memory word depends on address; released bus shows the inverse
   assign prog_data = prog_rd_n ? ~(prog_addr[7:0] ^ 8'h5A)
                                : prog_addr[7:0] ^ 8'h5A;
   detector_model i_det (.phase(phase), .mag(mag), .rf_on(rf_on),
      .swr_high(swr_high), .tune_req(tune_req), .chan(chan),
      .det_pins(det_pins), .chan_n(chan_n));
   tuner_ctrl #(.RETUNE_CYCLES(50)) i_dut (.mclk(mclk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .det_pins(det_pins), .chan_n(chan_n), .prog_addr(prog_addr),
      .prog_rd_n(prog_rd_n), .prog_data(prog_data), .port_bus(port_bus),
      .port_wr_n(port_wr_n), .cap_relays(cap_relays),
      .ind_relays(ind_relays), .lamps(lamps), .irq(irq));
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_errors++;
         finish_test();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // reads until the bit shows the value; a bounded wait
   task automatic poll(input logic [11:0] a, input int b, input logic v);
      for (int k = 0; k < 300; k++) begin
         rd(a);
         if (rdat[b] === v) return;
      end
      n_errors++;
      finish_test();
   endtask
   initial begin
      idle(12);
      chk({cap_relays, ind_relays, lamps, irq, prog_rd_n, port_wr_n}, 32'h3);
      rst_n <= 1;
      idle(8);
      for (i = 0; i < 3; i++) begin
         phase <= 2'(i);
         mag <= 2'((i + 1) % 3);
         idle(8);
         rd(`REG_STATUS);
         chk(rdat[3:2], {i == 2, i == 0});
      end
      rd(12'h0FC);
      chk(err, 1'b1);
      chk(rdat, 32'h0);
      wr(`REG_PORT, {16'h0, `PORT_CAP, 8'hA5});
      wr(`REG_PORT, {16'h0, `PORT_IND, 8'h3C});
      wr(`REG_PORT, {16'h0, `PORT_LAMP, 8'h20});
      idle(4);
      chk({cap_relays, ind_relays, lamps}, 24'hA53C20);
      wr(`REG_PROG_ADDR, 32'h5A7);
      poll(`REG_PROG_DATA, 8, 1'b0);
      chk({prog_addr, rdat[8:0]}, {12'h5A7, 9'h0FD});
      wr(`REG_INT_MASK, 32'h0);
      wr(`REG_INT_STAT, 32'h3F);
      swr_high <= 1;
      idle(8);
      rd(`REG_INT_STAT);
      chk({irq, rdat[0]}, 2'b01);
      wr(`REG_INT_MASK, 32'h1);
      idle(1);
      chk(irq, 1'b1);
      wr(`REG_INT_STAT, 32'h1);
      idle(1);
      chk(irq, 1'b0);
      // retune: wake with vswr held low, auto retune on
      wr(`REG_CTRL, 32'h1);
      swr_high <= 0;
      idle(8);
      wr(`REG_INT_STAT, 32'h3F);
      // carrier on, else the watch state goes straight back to sleep
      rf_on <= 1; swr_high <= 1;
      idle(20);
      rd(`REG_INT_STAT);
      chk(rdat[3], 1'b0);
      idle(60);
      rd(`REG_INT_STAT);
      chk(rdat[3], 1'b1);
      wr(`REG_CTRL, 32'h0);
      idle(20);
      // tune out of window, then drop the carrier
      rf_on <= 1; tune_req <= 1; phase <= 1; mag <= 0; swr_high <= 0;
      idle(30);
      rd(`REG_STATUS);
      chk(rdat[7], 1'b0);
      rf_on <= 0;
      poll(`REG_STATUS, 1, 1'b1);
      chk(rdat[1], 1'b1);
      wr(`REG_INT_STAT, 32'h3F);
      rf_on <= 1; phase <= 0; swr_high <= 1;
      idle(8);
      swr_high <= 0;
      poll(`REG_STATUS, 7, 1'b1);
      rd(`REG_INT_STAT);
      chk(rdat[2:1], 2'b11);
      tune_req <= 0;
      wr(`REG_CTRL, 32'h4);
      wr(`REG_RELAY, 32'h12345);
      wr(`REG_CTRL, 32'h2);
      rd(`REG_CHAN);
      chk(rdat, 32'h1);
      chan <= 5'h0D;
      idle(10);
      rd(`REG_CHAN);
      chk(rdat, 32'hD);
      wr(`REG_INT_STAT, 32'h3F);
      chan <= 5'h01;
      poll(`REG_INT_STAT, 4, 1'b1);
      idle(40);
      rd(`REG_RELAY);
      chk(rdat[20:0], 21'h12345);
      rd(`REG_STATUS);
      chk(rdat[1], 1'b1);
      finish_test();
   end
endmodule // antenna_tuner_status_control_bench

/* testbench/detector_model.sv */
// behavioural detectors and transceiver channel lines
`timescale 1ns/1ps
module detector_model
   import tuner_ctrl_pkg::*;
(
   // levels set by the bench: 0 in window, 1 above, 2 below
   input  wire logic [1:0] phase,
   input  wire logic [1:0] mag,
   input  wire logic       rf_on,
   input  wire logic       swr_high,
   input  wire logic       tune_req,
   input  wire logic [4:0] chan,
   // pins towards the controller
   output      detect_t    det_pins,
   output      logic [4:0] chan_n
);
   always_comb begin
      det_pins.phase_pos_n       = !(phase == 2'h1);
      det_pins.phase_neg_n       = !(phase == 2'h2);
      det_pins.impedance_high_n  = !(mag == 2'h1);
      det_pins.impedance_low_n   = !(mag == 2'h2);
      det_pins.carrier_present_n = !rf_on;
      det_pins.vswr_ok           = !swr_high;
      det_pins.tune_cmd          = tune_req;
      // channel 20 has no code on five lines, so it is never offered
      chan_n = ~{chan >= 5'h0A, 4'(chan % 5'h0A)};
   end
endmodule // detector_model

/* testbench/tuner_ctrl_sva.sv */
// port checks for the tuner controller
`timescale 1ns/1ps
`include "tuner_ctrl_defs.svh"
module tuner_ctrl_sva
   import tuner_ctrl_pkg::*;
#(
   parameter int unsigned RETUNE_CYCLES = 50
) (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // fetch and ports
   input wire logic [11:0] prog_addr,
   input wire logic        prog_rd_n,
   input wire port_wr_t    port_bus,
   input wire logic        port_wr_n,
   input wire logic [7:0]  cap_relays,
   input wire logic [7:0]  ind_relays,
   input wire logic [7:0]  lamps
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire acc = psel && penable;
   sequence s_wr(logic [7:0] code);
      !port_wr_n && port_bus.sel == code;
   endsequence
   sequence s_pulse(logic sig);
      $fell(sig) ##1 sig;
   endsequence
   property p_latch(logic [7:0] code, logic [7:0] out);
      s_wr(code) |=> out == $past(port_bus.data);
   endproperty
   a_rd_pulse_brief: assert property ($fell(prog_rd_n) |-> s_pulse(prog_rd_n))
      else $error("fetch strobe longer than one cycle");
   a_fetch_addr_held: assert property (!prog_rd_n |-> $stable(prog_addr))
      else $error("fetch address moved under strobe");
   a_wr_pulse_brief: assert property ($fell(port_wr_n) |-> s_pulse(port_wr_n))
      else $error("port strobe longer than one cycle");
   a_port_strobe_follows: assert property (acc && pwrite && paddr == `REG_PORT |-> ##[1:3] !port_wr_n)
      else $error("port write gave no strobe");
   a_cap_port_latch: assert property (p_latch(`PORT_CAP, cap_relays))
      else $error("capacitor port not latched");
   a_ind_port_latch: assert property (p_latch(`PORT_IND, ind_relays))
      else $error("inductor port not latched");
   a_lamp_port_latch: assert property (p_latch(`PORT_LAMP, lamps))
      else $error("lamp port not latched");
   a_zero_wait: assert property (acc |-> pready)
      else $error("access not answered at once");
   a_unmapped_err: assert property (acc && paddr > `REG_PROG_DATA |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_idle_rdata: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
endmodule // tuner_ctrl_sva
bind tuner_ctrl tuner_ctrl_sva #(.RETUNE_CYCLES(RETUNE_CYCLES)) i_sva (
   .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .prog_addr(prog_addr), .prog_rd_n(prog_rd_n),
   .port_bus(port_bus), .port_wr_n(port_wr_n), .cap_relays(cap_relays),
   .ind_relays(ind_relays), .lamps(lamps));
